// *** core/ccopd_ctrl.sv ***
// ccopd_ctrl: output stop and power-down control for a clock synthesizer
// assumes stop pins synchronous to sys_clk; power_down_n is asynchronous
`timescale 1ns/1ps

// What this block does
// (RULE1) halt stoppable cpu outputs after two falling samples
// (RULE2) only masked cpu outputs obey cpu halt
// (RULE3) stopped cpu: true high, complement undriven
// (RULE4) other clocks keep running during cpu halt
// (RULE5) cpu restart without short or long pulses
// (RULE6) cpu outputs active within two cycles
// (RULE7) free-running pci outputs ignore pci halt
// (RULE8) pci halt enable is pin and register
// (RULE9) readback bit3 shows pin and register
// (RULE10) pci clocks resume within two periods
// (RULE11) pci stop changes at free-running rising edge
// (RULE12) bit5 selects 66 or 48 mhz mode
// (RULE13) 66 mode carries spreading when enabled
// (RULE14) 48 mode phase aligned with 48 clocks
// (RULE15) mode switch may glitch, meant for power-on
// (RULE16) usb and display 48 clocks in phase
// (RULE17) synchronize power-down input before use
// (RULE18) power-down holds non-cpu clocks low, pll off
// (RULE19) two complement samples, then pci_f, then 66b
// (RULE20) remaining clocks stop at own falling edge
// (RULE21) power-down cpu true high at twice reference
// (RULE22) pll shut only after last clock stops
// (RULE23) power-down stops are glitch free
// (RULE24) clocks restart under 3.0 ms after release; here the relock wait alone takes 3.0 ms
// (RULE25) pci run register bit resets to one
module ccopd_ctrl #(
  parameter int unsigned RESTART_CYCLES = ccopd_pkg::PD_RESTART_CYCLES
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // stop and power-down pins
  input  wire logic        cpu_clock_halt_n,
  input  wire logic        pci_clock_halt_n,
  input  wire logic        power_down_n,
  // differential cpu outputs
  output logic      [2:0]  cpu_true,
  output logic      [2:0]  cpu_comp,
  output logic      [2:0]  cpu_comp_oe,
  output logic      [2:0]  cpu_iref_mult,
  // single-ended clock outputs
  output logic      [2:0]  pci_free,
  output logic      [6:0]  pci_clk,
  output logic      [2:0]  buffered_66m_outputs,
  output logic             bus_66m_output,
  output logic             dual_function_output,
  output logic             usb_48m_clock,
  output logic             display_48m_clock,
  // spreading and pll status
  output logic             dual_ssc_active,
  output logic             pll_power_down
);

  // configuration registers
  logic [2:0] cpu_mask_r;
  logic [2:0] pcif_free_r;
  logic       pci_run_r;
  logic       video_r;
  logic       spread_r;
  logic       mult_r;

  // dividers: phase registers and counters
  logic       cpu_ph_r;
  logic [1:0] c66_r;
  logic       ph66_r;
  logic       pci_ph_r;
  logic [1:0] c48_r;
  logic       ph48_r;

  // stop state
  logic [1:0] cpu_lo_cnt_r;
  logic [2:0] cpu_held_r;
  logic       pci_halt_r;
  logic       pd_meta_r;
  logic       pd_sync_r;
  logic [1:0] pd_lo_cnt_r;
  logic       cpu_pd_r;
  logic       off_pcif_r;
  logic       off_b66_r;
  logic       off_pci_r;
  logic       off_bus_r;
  logic       off_48_r;
  logic [16:0] wake_cnt_r;
  ccopd_pkg::ccopd_pd_state_t pd_st_r;
  ccopd_pkg::ccopd_pd_state_t pd_st_nxt;

  // terminal count of a divider half period
  function automatic logic at_half(input logic [1:0] cnt,
                                   input logic [1:0] half);
    at_half = (cnt == half - 2'h1);
  endfunction

  // next value of a power-down off flag: set at own fall, clear at rise
  function automatic logic off_next(input logic cur, input logic stop_ok,
                                    input logic fall, input logic rise,
                                    input logic run);
    if (stop_ok && fall) begin
      off_next = 1'b1;
    end else if (run && rise) begin
      off_next = 1'b0;
    end else begin
      off_next = cur;
    end
  endfunction

  // edge ticks: an output flips at the next edge when its tick is high
  wire tog66     = at_half(c66_r, ccopd_pkg::HALF_66);
  wire tog48     = at_half(c48_r, ccopd_pkg::HALF_48);
  wire cpu_fall  = cpu_ph_r;              // cpu toggles every cycle
  wire fall66    = tog66 && ph66_r;
  wire rise66    = tog66 && !ph66_r;
  wire pci_tog   = rise66;                // pci runs at half of 66
  wire pci_fall  = pci_tog && pci_ph_r;
  wire pci_rise  = pci_tog && !pci_ph_r;
  wire fall48    = tog48 && ph48_r;
  wire rise48    = tog48 && !ph48_r;
  wire ph66_nxt  = tog66 ? !ph66_r : ph66_r;
  wire pci_ph_nxt = pci_tog ? !pci_ph_r : pci_ph_r;
  wire ph48_nxt  = tog48 ? !ph48_r : ph48_r;

  // register decode
  wire wr_ctrl  = reg_wr && (reg_addr == ccopd_pkg::CTRL_ADDR);
  wire wr_mask  = reg_wr && (reg_addr == ccopd_pkg::CPU_MASK_ADDR);
  wire wr_free  = reg_wr && (reg_addr == ccopd_pkg::PCIF_FREE_ADDR);

  // (RULE8) and of pin and register bit
  wire pci_run_eff = pci_clock_halt_n && pci_run_r;

  // cpu halt request after two consecutive low falling-edge samples
  wire cpu_req   = (cpu_lo_cnt_r == 2'h2);
  wire pd_run    = (pd_st_r == ccopd_pkg::PD_RUN);
  wire in_pd     = !pd_run && (pd_st_r != ccopd_pkg::PD_WAKE);
  wire dual_off  = video_r ? off_48_r : off_bus_r;
  wire all_off   = off_pcif_r && off_b66_r && off_pci_r && off_bus_r &&
                   off_48_r;
  wire rest_ok   = (pd_st_r == ccopd_pkg::PD_STOP_REST);

  // (RULE1) count low samples taken on falling cpu edges
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cpu_lo_cnt_r <= 2'h0;
    end else if (cpu_fall) begin
      if (cpu_clock_halt_n) begin
        cpu_lo_cnt_r <= 2'h0;
      end else if (!cpu_req) begin
        cpu_lo_cnt_r <= cpu_lo_cnt_r + 2'h1;
      end
    end
  end

  // (RULE2) per-output hold, changed only where the true output goes low
  // holding at that point keeps the last high, restart gives a full low
  logic [2:0] cpu_held_nxt;
  // (RULE5) (RULE6) release takes effect at the next falling edge
  assign cpu_held_nxt = cpu_fall ? ((cpu_req ? cpu_mask_r : 3'h0) |
                                    {3{cpu_pd_r || in_pd}})
                                 : cpu_held_r;

  // (RULE3) held pair: true high, complement released at unchanged current
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cpu_ph_r    <= 1'b0;
      cpu_held_r  <= 3'h0;
      cpu_pd_r    <= 1'b0;
      cpu_true    <= 3'h0;
      cpu_comp    <= 3'h0;
      cpu_comp_oe <= 3'h0;
    end else begin
      cpu_ph_r    <= !cpu_ph_r;
      cpu_held_r  <= cpu_held_nxt;
      cpu_pd_r    <= cpu_fall ? in_pd : cpu_pd_r;
      cpu_true    <= cpu_held_nxt | {3{!cpu_ph_r}};
      cpu_comp    <= ~cpu_held_nxt & {3{cpu_ph_r}};
      cpu_comp_oe <= ~cpu_held_nxt;
    end
  end

  // (RULE21) current multiple: register choice, fixed at two in power-down
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cpu_iref_mult <= ccopd_pkg::MULT_LOW;
    end else if (in_pd) begin
      cpu_iref_mult <= ccopd_pkg::MULT_PD;
    end else begin
      cpu_iref_mult <= mult_r ? ccopd_pkg::MULT_HIGH : ccopd_pkg::MULT_LOW;
    end
  end

  // (RULE4) dividers keep running whatever the cpu hold state
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      c66_r    <= 2'h0;
      ph66_r   <= 1'b0;
      pci_ph_r <= 1'b0;
      c48_r    <= 2'h0;
      ph48_r   <= 1'b0;
    end else begin
      c66_r    <= tog66 ? 2'h0 : c66_r + 2'h1;
      ph66_r   <= ph66_nxt;
      pci_ph_r <= pci_ph_nxt;
      c48_r    <= tog48 ? 2'h0 : c48_r + 2'h1;
      ph48_r   <= ph48_nxt;
    end
  end

  // (RULE11) pci halt state moves only at the free-running rising edge
  // (RULE10) so a release resumes the clocks within one pci period
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pci_halt_r <= 1'b0;
    end else if (pci_rise) begin
      pci_halt_r <= !pci_run_eff;
    end
  end
  wire pci_halt_nxt = pci_rise ? !pci_run_eff : pci_halt_r;

  // (RULE17) two-flop synchroniser for the asynchronous power-down pin
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pd_meta_r <= 1'b1;
      pd_sync_r <= 1'b1;
    end else begin
      pd_meta_r <= power_down_n;
      pd_sync_r <= pd_meta_r;
    end
  end

  // (RULE19) complement rises where the true output falls
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pd_lo_cnt_r <= 2'h0;
    end else if (!pd_run || pd_sync_r) begin
      pd_lo_cnt_r <= 2'h0;
    end else if (cpu_fall && pd_lo_cnt_r != 2'h2) begin
      pd_lo_cnt_r <= pd_lo_cnt_r + 2'h1;
    end
  end

  // power-down sequencer
  always_comb begin
    pd_st_nxt = pd_st_r;
    case (pd_st_r)
      ccopd_pkg::PD_RUN: begin
        if (pd_lo_cnt_r == 2'h2) begin
          pd_st_nxt = ccopd_pkg::PD_STOP_PCIF;
        end
      end
      // (RULE19) free-running pci first, then buffered 66
      ccopd_pkg::PD_STOP_PCIF: begin
        if (pci_fall) begin
          pd_st_nxt = ccopd_pkg::PD_STOP_66B;
        end
      end
      ccopd_pkg::PD_STOP_66B: begin
        if (fall66) begin
          pd_st_nxt = ccopd_pkg::PD_STOP_REST;
        end
      end
      // (RULE22) generator shuts down only once every single-ended output is low
      ccopd_pkg::PD_STOP_REST: begin
        if (all_off) begin
          pd_st_nxt = ccopd_pkg::PD_DOWN;
        end
      end
      ccopd_pkg::PD_DOWN: begin
        if (pd_sync_r) begin
          pd_st_nxt = ccopd_pkg::PD_WAKE;
        end
      end
      // (RULE24) relock wait lasts RESTART_CYCLES + 1 cycles, the full 3.0 ms restart limit by default
      ccopd_pkg::PD_WAKE: begin
        if (wake_cnt_r == 17'(RESTART_CYCLES)) begin
          pd_st_nxt = ccopd_pkg::PD_RUN;
        end
      end
      default: begin
        pd_st_nxt = ccopd_pkg::PD_RUN;
      end
    endcase
  end

  // state register and relock counter
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pd_st_r    <= ccopd_pkg::PD_RUN;
      wake_cnt_r <= 17'h0_0000;
    end else begin
      pd_st_r    <= pd_st_nxt;
      wake_cnt_r <= (pd_st_r == ccopd_pkg::PD_WAKE) ?
                    wake_cnt_r + 17'h0_0001 : 17'h0_0000;
    end
  end

  // (RULE20) (RULE23) each group stops low at its own falling edge and
  // restarts at its own rising edge, so no pulse is ever shortened
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      off_pcif_r <= 1'b0;
      off_b66_r  <= 1'b0;
      off_pci_r  <= 1'b0;
      off_bus_r  <= 1'b0;
      off_48_r   <= 1'b0;
    end else begin
      off_pcif_r <= off_next(off_pcif_r, in_pd, pci_fall, pci_rise, pd_run);
      off_b66_r  <= off_next(off_b66_r,
                             in_pd && pd_st_r != ccopd_pkg::PD_STOP_PCIF,
                             fall66, rise66, pd_run);
      off_pci_r  <= off_next(off_pci_r, rest_ok, pci_fall, pci_rise, pd_run);
      off_bus_r  <= off_next(off_bus_r, rest_ok, fall66, rise66, pd_run);
      off_48_r   <= off_next(off_48_r, rest_ok, fall48, rise48, pd_run);
    end
  end

  // (RULE18) pll off while powered down; off flags hold clocks low
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pll_power_down <= 1'b0;
    end else begin
      pll_power_down <= (pd_st_nxt == ccopd_pkg::PD_DOWN);
    end
  end

  // next values of the single-ended outputs, each from the phase after
  // this edge gated by the group's stop flag as it stands after the edge
  wire pcif_off_nxt = off_next(off_pcif_r, in_pd, pci_fall, pci_rise,
                               pd_run);
  wire b66_off_nxt  = off_next(off_b66_r,
                               in_pd && pd_st_r != ccopd_pkg::PD_STOP_PCIF,
                               fall66, rise66, pd_run);
  wire pci_off_nxt  = off_next(off_pci_r, rest_ok, pci_fall, pci_rise,
                               pd_run);
  wire bus_off_nxt  = off_next(off_bus_r, rest_ok, fall66, rise66, pd_run);
  wire g48_off_nxt  = off_next(off_48_r, rest_ok, fall48, rise48, pd_run);
  wire pci_run_nxt  = pci_ph_nxt && !pci_halt_nxt;
  // (RULE7) free-running pci_f outputs skip the pci halt
  wire [2:0] pcif_nxt = {3{pci_ph_nxt && !pcif_off_nxt}} &
                        (pcif_free_r | {3{!pci_halt_nxt}});
  wire g48_nxt      = ph48_nxt && !g48_off_nxt;
  // (RULE12) (RULE14) dual output from the 66 or the shared 48 phase
  // (RULE15) source swaps on the write itself and may glitch once
  wire dual_nxt     = video_r ? g48_nxt : (ph66_nxt && !bus_off_nxt);

  // single-ended output flops
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pci_free             <= 3'h0;
      pci_clk              <= 7'h00;
      buffered_66m_outputs <= 3'h0;
      bus_66m_output       <= 1'b0;
      dual_function_output <= 1'b0;
      usb_48m_clock        <= 1'b0;
      display_48m_clock    <= 1'b0;
    end else begin
      pci_free             <= pcif_nxt;
      pci_clk              <= {7{pci_run_nxt && !pci_off_nxt}};
      buffered_66m_outputs <= {3{ph66_nxt && !b66_off_nxt}};
      bus_66m_output       <= ph66_nxt && !bus_off_nxt;
      dual_function_output <= dual_nxt;
      // (RULE16) both 48 outputs from one phase and one stop flag
      usb_48m_clock        <= g48_nxt;
      display_48m_clock    <= g48_nxt;
    end
  end

  // (RULE13) spreading applies to the dual output only in 66 mode
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      dual_ssc_active <= 1'b0;
    end else begin
      dual_ssc_active <= spread_r && !video_r && !dual_off;
    end
  end

  // configuration writes
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      // (RULE25) pci clocks run after reset
      pci_run_r   <= ccopd_pkg::PCI_RUN_RST;
      video_r     <= ccopd_pkg::VIDEO_RST;
      spread_r    <= ccopd_pkg::SPREAD_RST;
      mult_r      <= ccopd_pkg::MULT_RST;
      cpu_mask_r  <= ccopd_pkg::CPU_MASK_RST;
      pcif_free_r <= ccopd_pkg::PCIF_FREE_RST;
    end else begin
      if (wr_ctrl) begin
        pci_run_r <= reg_wdata[ccopd_pkg::CTRL_PCI_RUN_BIT];
        video_r   <= reg_wdata[ccopd_pkg::CTRL_VIDEO_BIT];
        spread_r  <= reg_wdata[ccopd_pkg::CTRL_SPREAD_BIT];
        mult_r    <= reg_wdata[ccopd_pkg::CTRL_MULT_BIT];
      end
      if (wr_mask) begin
        cpu_mask_r <= reg_wdata[2:0];
      end
      if (wr_free) begin
        pcif_free_r <= reg_wdata[2:0];
      end
    end
  end

  // read mux; unmapped addresses read as zero
  logic [7:0] ctrl_rd;
  logic [7:0] stat_rd;
  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[ccopd_pkg::CTRL_MULT_BIT]    = mult_r;
    ctrl_rd[ccopd_pkg::CTRL_SPREAD_BIT]  = spread_r;
    // (RULE9) reads back the effective enable, not the stored bit
    ctrl_rd[ccopd_pkg::CTRL_PCI_RUN_BIT] = pci_run_eff;
    ctrl_rd[ccopd_pkg::CTRL_VIDEO_BIT]   = video_r;
    stat_rd = 8'h00;
    stat_rd[ccopd_pkg::STAT_CPU_HALT_BIT] = |cpu_held_r;
    stat_rd[ccopd_pkg::STAT_PCI_HALT_BIT] = pci_halt_r;
    stat_rd[ccopd_pkg::STAT_PD_BIT]       = !pd_run;
    stat_rd[ccopd_pkg::STAT_PLL_OFF_BIT]  = pll_power_down;
  end

  wire [7:0] rd_mux =
    (reg_addr == ccopd_pkg::CTRL_ADDR)      ? ctrl_rd :
    (reg_addr == ccopd_pkg::CPU_MASK_ADDR)  ? {5'h00, cpu_mask_r} :
    (reg_addr == ccopd_pkg::PCIF_FREE_ADDR) ? {5'h00, pcif_free_r} :
    (reg_addr == ccopd_pkg::STATUS_ADDR)    ? stat_rd : 8'h00;

  // read data valid the cycle after the strobe only
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 8'h00;
    end
  end

endmodule

// *** include/ccopd_pkg.sv ***
// ccopd_pkg: constants shared by the clock output stop / power-down block
// assumes a single 25 MHz system clock and an 8-bit register port
package ccopd_pkg;

  // register port geometry
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // register byte addresses
  localparam logic [3:0] CTRL_ADDR     = 4'h0;
  localparam logic [3:0] CPU_MASK_ADDR = 4'h4;
  localparam logic [3:0] PCIF_FREE_ADDR = 4'h8;
  localparam logic [3:0] STATUS_ADDR   = 4'hc;

  // control register field positions
  localparam int unsigned CTRL_MULT_BIT   = 0;
  localparam int unsigned CTRL_SPREAD_BIT = 1;
  localparam int unsigned CTRL_PCI_RUN_BIT = 3;
  localparam int unsigned CTRL_VIDEO_BIT  = 5;

  // status register field positions
  localparam int unsigned STAT_CPU_HALT_BIT = 0;
  localparam int unsigned STAT_PCI_HALT_BIT = 1;
  localparam int unsigned STAT_PD_BIT       = 2;
  localparam int unsigned STAT_PLL_OFF_BIT  = 3;

  // reset values
  localparam logic       PCI_RUN_RST   = 1'b1;
  localparam logic       VIDEO_RST     = 1'b0;
  localparam logic       SPREAD_RST    = 1'b0;
  localparam logic       MULT_RST      = 1'b0;
  localparam logic [2:0] CPU_MASK_RST  = 3'h7;
  localparam logic [2:0] PCIF_FREE_RST = 3'h0;

  // output current multiples of the reference current
  localparam logic [2:0] MULT_LOW  = 3'h4;
  localparam logic [2:0] MULT_HIGH = 3'h6;
  localparam logic [2:0] MULT_PD   = 3'h2;

  // divider half periods in system clock cycles (modelled rates)
  localparam logic [1:0] HALF_66 = 2'h2;
  localparam logic [1:0] HALF_48 = 2'h3;

  // timing: restart latency after power-down release
  localparam int unsigned SYS_CLK_PERIOD_NS = 40;
  localparam int unsigned PD_RESTART_NS     = 3000000;
  // strictly less than the restart time, so one cycle short
  localparam int unsigned PD_RESTART_CYCLES =
    PD_RESTART_NS / SYS_CLK_PERIOD_NS - 1;

  // power-down sequencer states
  typedef enum logic [2:0] {
    PD_RUN       = 3'b000,
    PD_STOP_PCIF = 3'b001,
    PD_STOP_66B  = 3'b010,
    PD_STOP_REST = 3'b011,
    PD_DOWN      = 3'b100,
    PD_WAKE      = 3'b101
  } ccopd_pd_state_t;

endpackage

// *** test/ccopd_ctrl_checker.sv ***
// ccopd_ctrl_checker: port assertions for the stop and power-down block
// assumes one sys_clk domain with synchronous active-high srst
`timescale 1ns/1ps
module ccopd_ctrl_checker #(
  parameter int unsigned RESTART_CYCLES = 20
) (
  // clock, reset and pins
  input wire logic       sys_clk,
  input wire logic       srst,
  input wire logic       cpu_clock_halt_n,
  input wire logic       pci_clock_halt_n,
  input wire logic       power_down_n,
  // clock outputs
  input wire logic [2:0] cpu_true,
  input wire logic [2:0] cpu_comp,
  input wire logic [2:0] cpu_comp_oe,
  input wire logic [2:0] cpu_iref_mult,
  input wire logic [2:0] pci_free,
  input wire logic [6:0] pci_clk,
  input wire logic [2:0] buffered_66m_outputs,
  input wire logic       bus_66m_output,
  input wire logic       dual_function_output,
  input wire logic       usb_48m_clock,
  input wire logic       display_48m_clock,
  input wire logic       pll_power_down
);
  // wake time plus one pci period and some margin
  localparam int RST_MAX = RESTART_CYCLES + 16;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);

  // every non-cpu clock low at once
  wire quiet = (pci_free | buffered_66m_outputs) == 3'h0 &&
    pci_clk == 7'h0 && !bus_66m_output && !dual_function_output &&
    !usb_48m_clock && !display_48m_clock;

  sequence s_pci_off;
    !pci_clock_halt_n [*8];
  endsequence
  sequence s_cpu_off;
    (!cpu_clock_halt_n && power_down_n && !pll_power_down) [*3];
  endsequence

  a_pd_clocks_low: assert property (
    pll_power_down |-> quiet) else $error("clock running in power-down");
  a_pll_after_stop: assert property (
    $rose(pll_power_down) |-> $past(quiet))
    else $error("pll off before clocks stopped");
  a_pd_cpu_high: assert property (
    pll_power_down |-> cpu_true == 3'h7 && cpu_comp_oe == 3'h0 &&
    cpu_iref_mult == ccopd_pkg::MULT_PD) else $error("cpu pair in pd");
  a_48m_phase: assert property (
    usb_48m_clock == display_48m_clock) else $error("48m clocks apart");
  // an undriven complement must rest low with its true output high
  a_held_pair: assert property (
    !$past(srst) |-> ((~cpu_comp_oe & ~cpu_true) |
    (~cpu_comp_oe & cpu_comp)) == 3'h0) else $error("held cpu pair");
  a_cpu_entry: assert property (
    |($past(cpu_comp_oe) & ~cpu_comp_oe) && power_down_n |->
    $past(cpu_clock_halt_n, 3) == 1'b0) else $error("early cpu halt");
  a_cpu_release: assert property (
    $rose(cpu_clock_halt_n) && power_down_n |-> ##[1:4]
    cpu_comp_oe == 3'h7) else $error("cpu restart late");
  a_others_run: assert property (
    s_cpu_off |-> bus_66m_output != $past(bus_66m_output, 2))
    else $error("66m clock stalled by cpu halt");
  a_pci_halt_low: assert property (
    s_pci_off ##1 s_pci_off |-> pci_clk == 7'h0)
    else $error("pci clock running while halted");
  a_pd_restart: assert property (
    $fell(pll_power_down) |-> ##[1:RST_MAX] pci_free != 3'h0)
    else $error("no restart after power-down");
endmodule

bind ccopd_ctrl ccopd_ctrl_checker #(
  .RESTART_CYCLES(RESTART_CYCLES)
) u_chk (
  .sys_clk, .srst, .cpu_clock_halt_n, .pci_clock_halt_n, .power_down_n,
  .cpu_true, .cpu_comp, .cpu_comp_oe, .cpu_iref_mult, .pci_free,
  .pci_clk, .buffered_66m_outputs, .bus_66m_output,
  .dual_function_output, .usb_48m_clock, .display_48m_clock,
  .pll_power_down
);

// *** test/ccopd_pm_model.sv ***
// ccopd_pm_model: chipset power-management logic driving the stop pins
// assumes the bench raises a request level for each stop it wants
`timescale 1ns/1ps
module ccopd_pm_model (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic srst,
  // requests, high asks for a stop
  input  wire logic cpu_req,
  input  wire logic pci_req,
  input  wire logic pd_req,
  // pins toward the device
  output logic      cpu_clock_halt_n = 1'b1,
  output logic      pci_clock_halt_n = 1'b1,
  output logic      power_down_n     = 1'b1
);
  // stop pins move just after the edge, as synchronous logic does
  always @(posedge sys_clk) begin
    cpu_clock_halt_n <= !(cpu_req && !srst);
    pci_clock_halt_n <= !(pci_req && !srst);
  end

  // power-down is asynchronous: moved mid-cycle to exercise the sync
  always @(posedge sys_clk) begin
    power_down_n <= #13 !(pd_req && !srst);
  end
endmodule

// *** test/ccopd_ctrl_tb.sv ***
// ccopd_ctrl_tb: self-checking bench for the stop and power-down block
// assumes the pm model drives the pins; register port driven here
`timescale 1ns/1ps
module ccopd_ctrl_tb;
  localparam int RESTART = 20;
  logic       sys_clk   = 1'b0;
  logic       srst      = 1'b1;
  logic [3:0] reg_addr  = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic       cpu_req   = 1'b0;
  logic       pci_req   = 1'b0;
  logic       pd_req    = 1'b0;
  logic       cpu_clock_halt_n, pci_clock_halt_n, power_down_n;
  logic [7:0] reg_rdata;
  logic [2:0] cpu_true, cpu_comp, cpu_comp_oe, cpu_iref_mult;
  logic [2:0] pci_free, buffered_66m_outputs;
  logic [6:0] pci_clk;
  logic       bus_66m_output, dual_function_output, usb_48m_clock;
  logic       display_48m_clock, dual_ssc_active, pll_power_down;
  int         bad_count  = 0;
  int         num_checks = 0;
  int         cyc_cnt    = 0;

  // 25 MHz system clock
  always #20 sys_clk = ~sys_clk;

  ccopd_ctrl #(.RESTART_CYCLES(RESTART)) DUT (
    .sys_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .cpu_clock_halt_n, .pci_clock_halt_n, .power_down_n, .cpu_true,
    .cpu_comp, .cpu_comp_oe, .cpu_iref_mult, .pci_free, .pci_clk,
    .buffered_66m_outputs, .bus_66m_output, .dual_function_output,
    .usb_48m_clock, .display_48m_clock, .dual_ssc_active, .pll_power_down
  );

  ccopd_pm_model PM (
    .sys_clk, .srst, .cpu_req, .pci_req, .pd_req,
    .cpu_clock_halt_n, .pci_clock_halt_n, .power_down_n
  );

  task results;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // bus cycles start on a rising edge, so strobes never clash
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask

  task pins(input logic c, input logic p, input logic d);
    @(posedge sys_clk);
    cpu_req <= c;
    pci_req <= p;
    pd_req  <= d;
  endtask

  task wait_n(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // gather which pci outputs went high over one pci period
  task acc8(output logic [6:0] a, output logic [2:0] f);
    a = 7'h00;
    f = 3'h0;
    repeat (8) begin
      @(negedge sys_clk);
      a |= pci_clk;
      f |= pci_free;
    end
  endtask

  task t_regs;
    logic [7:0] v;
    rd(ccopd_pkg::CTRL_ADDR, v);
    chk(v, 8'h08);
    rd(ccopd_pkg::CPU_MASK_ADDR, v);
    chk(v, 8'h07);
    rd(ccopd_pkg::PCIF_FREE_ADDR, v);
    chk(v, 8'h00);
    wr(4'h2, 8'hff);
    rd(4'h2, v);
    chk(v, 8'h00);
    $display("test regs done");
  endtask

  task t_pci;
    logic [7:0] v;
    logic [6:0] a;
    logic [2:0] f;
    int         n;
    wr(ccopd_pkg::CTRL_ADDR, 8'h00);
    rd(ccopd_pkg::CTRL_ADDR, v);
    chk(v, 8'h00);
    wait_n(12);
    acc8(a, f);
    chk(a, 8'h00);
    chk(f, 8'h00);
    wr(ccopd_pkg::CTRL_ADDR, 8'h08);
    wr(ccopd_pkg::PCIF_FREE_ADDR, 8'h05);
    pins(1'b0, 1'b1, 1'b0);
    rd(ccopd_pkg::CTRL_ADDR, v);
    chk(v, 8'h00);
    wait_n(12);
    rd(ccopd_pkg::STATUS_ADDR, v);
    chk(v, 8'h02);
    acc8(a, f);
    chk(f, 8'h05);
    chk(a, 8'h00);
    pins(1'b0, 1'b0, 1'b0);
    n = 0;
    while (pci_clk !== 7'h7f && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    chk(n <= 17, 8'h01);
    wr(ccopd_pkg::PCIF_FREE_ADDR, 8'h00);
    $display("test pci done");
  endtask

  task t_cpu;
    logic [7:0] v;
    logic [2:0] t_and, oe_or;
    int         n;
    wr(ccopd_pkg::CPU_MASK_ADDR, 8'h02);
    wr(ccopd_pkg::CTRL_ADDR, 8'h09);
    pins(1'b1, 1'b0, 1'b0);
    wait_n(12);
    t_and = 3'h7;
    oe_or = 3'h0;
    repeat (4) begin
      @(negedge sys_clk);
      t_and &= cpu_true;
      oe_or |= cpu_comp_oe;
    end
    chk(t_and, 8'h02);
    chk(oe_or, 8'h05);
    chk(cpu_iref_mult, ccopd_pkg::MULT_HIGH);
    rd(ccopd_pkg::STATUS_ADDR, v);
    chk(v, 8'h01);
    pins(1'b0, 1'b0, 1'b0);
    n = 0;
    while (cpu_comp_oe !== 3'h7 && n < 10) begin
      @(negedge sys_clk);
      n++;
    end
    chk(n <= 6, 8'h01);
    wr(ccopd_pkg::CPU_MASK_ADDR, 8'h07);
    wr(ccopd_pkg::CTRL_ADDR, 8'h08);
    $display("test cpu done");
  endtask

  task t_dual;
    logic [7:0] v;
    int         m;
    wr(ccopd_pkg::CTRL_ADDR, 8'h0a);
    wait_n(4);
    chk(dual_ssc_active, 8'h01);
    wr(ccopd_pkg::CTRL_ADDR, 8'h2a);
    rd(ccopd_pkg::CTRL_ADDR, v);
    chk(v, 8'h2a);
    wait_n(8);
    m = 0;
    repeat (12) begin
      @(negedge sys_clk);
      if (dual_function_output !== usb_48m_clock) m++;
    end
    chk(m, 8'h00);
    chk(dual_ssc_active, 8'h00);
    wr(ccopd_pkg::CTRL_ADDR, 8'h08);
    $display("test dual done");
  endtask

  task t_pd;
    logic [7:0] v;
    int         n, lf, lb, lp;
    pins(1'b0, 1'b0, 1'b1);
    n = 0;
    lf = 0;
    lb = 0;
    lp = 0;
    // note the last cycle the pci_f, buffered 66 and pci groups were still seen high
    while (pll_power_down !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
      if (pci_free != 3'h0) lf = n;
      if (buffered_66m_outputs != 3'h0) lb = n;
      if (pci_clk != 7'h0) lp = n;
    end
    chk(pll_power_down, 8'h01);
    chk(lf < lb, 8'h01);
    chk(lb <= lp, 8'h01);
    chk(cpu_true, 8'h07);
    chk(cpu_iref_mult, ccopd_pkg::MULT_PD);
    rd(ccopd_pkg::STATUS_ADDR, v);
    chk(v & 8'h0c, 8'h0c);
    pins(1'b0, 1'b0, 1'b0);
    n = 0;
    while (pci_free === 3'h0 && n < RESTART + 40) begin
      @(negedge sys_clk);
      n++;
    end
    chk(n < RESTART + 40, 8'h01);
    $display("test pd done");
  endtask

  // cut a hang short well beyond the expected run length
  always @(posedge sys_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      bad_count++;
      results();
    end
  end

  // main sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    t_regs();
    t_pci();
    t_cpu();
    t_dual();
    t_pd();
    results();
  end
endmodule
